// ==== hdl/cst_clock_select.sv ====
// Clock selection, dividers, interval timer and trim registers with AXI4-Lite access.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module cst_clock_select #(
    parameter int TIMER_BITS = 12,
    parameter int TICK_DIV = cst_pkg::CST_TICK_DIV
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clock sources, sampled as levels.
    input wire cst_pkg::cst_src_t src_in,
    // Pin and oscillator controls.
    output logic cpu_core_clock_en,
    output logic clock_out_pin,
    output logic ext_clock_in_pin,
    output logic port0_pin0_oe_n_force,
    output logic port0_pin1_oe_n_force,
    output logic input_glitch_filter_en,
    output logic crystal_osc_en,
    output logic low_power_osc_lowpwr,
    output logic [7:0] internal_main_osc_trim,
    output logic [7:0] crystal_osc_trim,
    output logic [7:0] low_power_osc_trim,
    // Events.
    output logic interval_irq,
    output logic tick_1024us
);
    import cst_pkg::*;

    // The tick counter is 13 bits wide, so the divider must fit in it.
    if (TIMER_BITS != 12 || TICK_DIV < 2 || TICK_DIV > 8192) begin
        $error("cst_clock_select: unsupported parameters");
    end

    // Sources come from foreign domains; two flops before any use.
    cst_src_t src_s1_reg, src_s2_reg, src_s3_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_s1_reg <= '0;
            src_s2_reg <= '0;
            src_s3_reg <= '0;
        end else begin
            src_s1_reg <= src_in;
            src_s2_reg <= src_s1_reg;
            src_s3_reg <= src_s2_reg;
        end
    end
    // Rising edges of the synchronised sources act as enable pulses.
    wire cst_src_t src_rise = src_s2_reg & ~src_s3_reg;

    // Registers.
    logic cpu_src_reg;
    logic [2:0] speed_reg;
    logic bank_reg;
    cst_tmr_cfg_t tmr_reg;
    logic [7:0] pin_reg, main_trim_reg, xtal_trim_reg, slow_trim_reg;
    logic [11:0] reload_reg;

    // External source: crystal if selected or enabled, else the pin through optional filter.
    wire xsel = pin_reg[CST_BIT_XSEL];
    wire xen = pin_reg[CST_BIT_XEN];
    wire ext_clock_in_pin_raw = xen ? src_s2_reg.xtal : src_s2_reg.pin0;
    wire ext_clock_in_pin_rise = xen ? src_rise.xtal : src_rise.pin0;
    wire ext_rise = xsel ? src_rise.xtal : ext_clock_in_pin_rise;
    wire ext_lvl = xsel ? src_s2_reg.xtal : ext_clock_in_pin_raw;

    // Capture clock source and even divider.
    wire cap_src_rise = (tmr_reg.cap_src == 2'h0) ? src_rise.osc_main :
        (tmr_reg.cap_src == 2'h1) ? ext_clock_in_pin_rise :
        (tmr_reg.cap_src == 2'h2) ? src_rise.osc_slow : 1'b0;
    logic [2:0] cap_cnt_reg;
    wire [2:0] cap_last = {tmr_reg.cap_div, 1'b1};
    wire cap_en = cap_src_rise && (cap_cnt_reg == cap_last);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_cnt_reg <= 3'h0;
        end else if (cap_src_rise) begin
            cap_cnt_reg <= cap_en ? 3'h0 : cap_cnt_reg + 3'h1;
        end
    end

    // Fixed tick counted from the capture clock.
    logic [12:0] tick_cnt_reg;
    logic tick_reg;
    wire tick_wrap = cap_en && (tick_cnt_reg == 13'(TICK_DIV - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= 13'h0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_wrap;
            if (cap_en) begin
                tick_cnt_reg <= tick_wrap ? 13'h0 : tick_cnt_reg + 13'h1;
            end
        end
    end

    // Interval clock source and 1..4 prescaler.
    wire itm_src_rise = (tmr_reg.itm_src == 2'h0) ? src_rise.osc_main :
        (tmr_reg.itm_src == 2'h1) ? ext_rise :
        (tmr_reg.itm_src == 2'h2) ? src_rise.osc_slow : cap_en;
    logic [1:0] itm_cnt_reg;
    wire itm_en = itm_src_rise && (itm_cnt_reg == tmr_reg.itm_div);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            itm_cnt_reg <= 2'h0;
        end else if (itm_src_rise) begin
            itm_cnt_reg <= itm_en ? 2'h0 : itm_cnt_reg + 2'h1;
        end
    end

    // Interval down counter; a zero count spends one clock on the reload.
    logic [11:0] count_reg;
    logic irq_reg;
    wire reload_now = itm_en && (count_reg == 12'h000);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 12'h000;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= reload_now;
            if (itm_en) begin
                count_reg <= reload_now ? reload_reg : count_reg - 12'h001;
            end
        end
    end

    // CPU clock divider: speed code selects the power of two.
    function automatic logic [6:0] speed_last(input logic [2:0] code);
        case (code)
            3'h0: speed_last = 7'h07;
            3'h1: speed_last = 7'h03;
            3'h2: speed_last = 7'h01;
            3'h4: speed_last = 7'h0F;
            3'h5: speed_last = 7'h1F;
            3'h6: speed_last = 7'h7F;
            default: speed_last = 7'h07;
        endcase
    endfunction
    wire cpu_src_rise = cpu_src_reg ? ext_rise : src_rise.osc_main;
    logic [6:0] cpu_cnt_reg;
    logic cpu_en_reg;
    wire cpu_en = cpu_src_rise && (cpu_cnt_reg >= speed_last(speed_reg));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_cnt_reg <= 7'h00;
            cpu_en_reg <= 1'b0;
        end else begin
            cpu_en_reg <= cpu_en;
            if (cpu_src_rise) begin
                cpu_cnt_reg <= cpu_en ? 7'h00 : cpu_cnt_reg + 7'h01;
            end
        end
    end

    // Clock-out mux; the divided CPU clock appears as its enable pulse.
    wire cout_next = (pin_reg[1:0] == 2'h0) ? src_s2_reg.osc_main :
        (pin_reg[1:0] == 2'h1) ? ext_lvl :
        (pin_reg[1:0] == 2'h2) ? src_s2_reg.osc_slow : cpu_en;

    // AXI4-Lite slave.
    cst_bus_t wst_reg, rst_reg;
    logic aw_got_reg, w_got_reg, w_lane_reg;
    logic [7:0] aw_addr_reg, w_data_reg;
    logic [7:0] rd_data_reg;
    logic rd_err_reg, wr_err_reg;
    // Offsets are word indices; the byte address is four times the index.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_got_reg || aw_take;
    wire have_w = w_got_reg || w_take;
    wire [7:0] waddr = aw_got_reg ? aw_addr_reg : s_axi_awaddr[9:2];
    wire [7:0] wdat = w_got_reg ? w_data_reg : s_axi_wdata[7:0];
    wire wlane = w_got_reg ? w_lane_reg : s_axi_wstrb[0];
    wire do_write = (wst_reg == CST_IDLE) && have_aw && have_w;
    function automatic logic addr_ok(input logic [7:0] a, input logic bank);
        addr_ok = (a == CST_OFF_CPU_SRC) || (a == CST_OFF_TMR_CFG) ||
            (a == CST_OFF_PIN_CFG) || (a == CST_OFF_MAIN_TRIM) ||
            (a == CST_OFF_XTAL_TRIM) || (a == CST_OFF_SLOW_TRIM) ||
            (a == CST_OFF_RELOAD_LO) || (a == CST_OFF_RELOAD_HI) ||
            (a == CST_OFF_FLAGS) || (a == CST_OFF_STATUS) ||
            ((a == CST_OFF_CPU_SPEED) && bank);
    endfunction
    wire wr_hit = do_write && wlane;
    wire wr_ok = addr_ok(waddr, bank_reg);
    wire wr_go = wr_hit && wr_ok;
    wire wr_speed = wr_go && (waddr == CST_OFF_CPU_SPEED) && bank_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_reg <= CST_IDLE;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            wr_err_reg <= 1'b0;
        end else begin
            case (wst_reg)
                CST_IDLE: begin
                    if (aw_take) begin
                        aw_got_reg <= 1'b1;
                        aw_addr_reg <= s_axi_awaddr[9:2];
                    end
                    if (w_take) begin
                        w_got_reg <= 1'b1;
                        w_data_reg <= s_axi_wdata[7:0];
                        w_lane_reg <= s_axi_wstrb[0];
                    end
                    if (do_write) begin
                        wst_reg <= CST_RESP;
                        wr_err_reg <= !wr_ok;
                        aw_got_reg <= 1'b0;
                        w_got_reg <= 1'b0;
                    end
                end
                CST_RESP: begin
                    if (s_axi_bready) begin
                        wst_reg <= CST_IDLE;
                    end
                end
                default: wst_reg <= CST_IDLE;
            endcase
        end
    end

    // Register writes; reset loads CST_RST_TRIM (zero) into the trimmed fields.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_src_reg <= 1'b0;
            speed_reg <= CST_RST_SPEED;
            bank_reg <= 1'b0;
            tmr_reg <= CST_RST_TMR_CFG;
            pin_reg <= CST_RST_PIN_CFG;
            main_trim_reg <= CST_RST_TRIM;
            xtal_trim_reg <= CST_RST_TRIM;
            slow_trim_reg <= CST_RST_TRIM;
            reload_reg <= 12'h000;
        end else if (wr_go) begin
            case (waddr)
                CST_OFF_CPU_SRC: cpu_src_reg <= wdat[0];
                CST_OFF_TMR_CFG: begin
                    // A stopped capture clock cannot be left by the interval source.
                    if (tmr_reg.itm_src == 2'h3 && tmr_reg.cap_src == 2'h3) begin
                        tmr_reg <= {wdat[7:2], 2'h3};
                    end else begin
                        tmr_reg <= wdat;
                    end
                end
                CST_OFF_PIN_CFG: pin_reg <= wdat & CST_MASK_PIN_CFG;
                CST_OFF_MAIN_TRIM: main_trim_reg <= wdat;
                CST_OFF_XTAL_TRIM: xtal_trim_reg <= wdat & CST_MASK_XTAL_TRIM;
                CST_OFF_SLOW_TRIM: slow_trim_reg <= wdat & CST_MASK_SLOW_TRIM;
                CST_OFF_RELOAD_LO: reload_reg[7:0] <= wdat;
                CST_OFF_RELOAD_HI: reload_reg[11:8] <= wdat[3:0];
                CST_OFF_FLAGS: bank_reg <= wdat[0];
                default: begin
                    if (wr_speed) begin
                        speed_reg <= wdat[2:0];
                    end
                end
            endcase
        end
    end

    // Read path.
    wire r_take = s_axi_arvalid && s_axi_arready;
    wire [7:0] raddr = s_axi_araddr[9:2];
    wire r_ok = addr_ok(raddr, bank_reg);
    wire [7:0] rmux = (raddr == CST_OFF_CPU_SRC) ? {7'h00, cpu_src_reg} :
        (raddr == CST_OFF_TMR_CFG) ? tmr_reg :
        (raddr == CST_OFF_PIN_CFG) ? pin_reg :
        (raddr == CST_OFF_MAIN_TRIM) ? main_trim_reg :
        (raddr == CST_OFF_XTAL_TRIM) ? xtal_trim_reg :
        (raddr == CST_OFF_SLOW_TRIM) ? slow_trim_reg :
        (raddr == CST_OFF_RELOAD_LO) ? reload_reg[7:0] :
        (raddr == CST_OFF_RELOAD_HI) ? {4'h0, reload_reg[11:8]} :
        (raddr == CST_OFF_FLAGS) ? {7'h00, bank_reg} :
        (raddr == CST_OFF_STATUS) ? count_reg[7:0] :
        (raddr == CST_OFF_CPU_SPEED && bank_reg) ? {5'h00, speed_reg} : 8'h00;
    // Ready flops announce one cycle ahead whether the next edge may take a request.
    wire aw_rdy_next = (wst_reg == CST_IDLE) ? (!do_write && !have_aw) :
        ((wst_reg == CST_RESP) && s_axi_bready);
    wire w_rdy_next = (wst_reg == CST_IDLE) ? (!do_write && !have_w) :
        ((wst_reg == CST_RESP) && s_axi_bready);
    wire ar_rdy_next = (rst_reg == CST_IDLE) ? !r_take :
        ((rst_reg == CST_RDAT) && s_axi_rready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_reg <= CST_IDLE;
            rd_data_reg <= 8'h00;
            rd_err_reg <= 1'b0;
        end else begin
            case (rst_reg)
                CST_IDLE: begin
                    if (r_take) begin
                        rst_reg <= CST_RDAT;
                        rd_data_reg <= r_ok ? rmux : 8'h00;
                        rd_err_reg <= !r_ok;
                    end
                end
                CST_RDAT: begin
                    if (s_axi_rready) begin
                        rst_reg <= CST_IDLE;
                    end
                end
                default: rst_reg <= CST_IDLE;
            endcase
        end
    end

    // Registered outputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            clock_out_pin <= 1'b0;
            ext_clock_in_pin <= 1'b0;
            port0_pin0_oe_n_force <= 1'b0;
            port0_pin1_oe_n_force <= 1'b0;
            input_glitch_filter_en <= 1'b1;
            crystal_osc_en <= 1'b0;
            low_power_osc_lowpwr <= 1'b0;
        end else begin
            s_axi_awready <= aw_rdy_next;
            s_axi_wready <= w_rdy_next;
            s_axi_arready <= ar_rdy_next;
            clock_out_pin <= cout_next;
            ext_clock_in_pin <= ext_clock_in_pin_raw;
            port0_pin0_oe_n_force <= xen;
            port0_pin1_oe_n_force <= xen;
            input_glitch_filter_en <= !pin_reg[CST_BIT_FBYP];
            crystal_osc_en <= xen;
            low_power_osc_lowpwr <= slow_trim_reg[CST_BIT_LOWPWR];
        end
    end
    assign s_axi_bvalid = (wst_reg == CST_RESP);
    assign s_axi_bresp = wr_err_reg ? 2'h2 : 2'h0;
    assign s_axi_rvalid = (rst_reg == CST_RDAT);
    assign s_axi_rdata = {24'h000000, rd_data_reg};
    assign s_axi_rresp = rd_err_reg ? 2'h2 : 2'h0;
    assign cpu_core_clock_en = cpu_en_reg;
    assign interval_irq = irq_reg;
    assign tick_1024us = tick_reg;
    assign internal_main_osc_trim = main_trim_reg;
    assign crystal_osc_trim = xtal_trim_reg;
    assign low_power_osc_trim = slow_trim_reg;

    chk_irq_after_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (itm_en && count_reg == 12'h000) |=> interval_irq)
        else $error("interrupt missing after reload");
    chk_irq_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
        interval_irq |=> !interval_irq)
        else $error("interrupt longer than one cycle");
    chk_reload_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (itm_en && count_reg == 12'h000) |=> count_reg == $past(reload_reg))
        else $error("reload value not loaded");
    chk_count_down: assert property (@(posedge aclk) disable iff (!aresetn)
        (itm_en && count_reg != 12'h000) |=> count_reg == $past(count_reg) - 12'h001)
        else $error("counter did not step down");
    chk_oe_forced: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(xen) |=> port0_pin0_oe_n_force && port0_pin1_oe_n_force)
        else $error("pin enables not forced off");
    chk_filter_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(pin_reg[CST_BIT_FBYP]) |=> input_glitch_filter_en != pin_reg[CST_BIT_FBYP])
        else $error("glitch filter control wrong");
    chk_speed_bank: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && !bank_reg) |=> $stable(speed_reg))
        else $error("speed changed outside second bank");
    chk_cap_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        (tmr_reg.cap_src == 2'h3) |-> !cap_en)
        else $error("stopped capture clock still ticks");
    chk_stuck_itm: assert property (@(posedge aclk) disable iff (!aresetn)
        (tmr_reg.itm_src == 2'h3 && tmr_reg.cap_src == 2'h3) |=> tmr_reg.itm_src == 2'h3)
        else $error("left a stopped capture clock");
endmodule

// ==== hdl/cst_pkg.sv ====
// Constants and types of the clock select and interval timer block.
// Overview of operation
// - CPU speed field resets to zero, giving 3 MHz from the internal oscillator.
// - Speed codes pick divide by 8,4,2,16,32,128; codes 011 and 111 reserved.
// - CPU speed register decodes only while the io bank select flag is set.
// - Crystal select bit makes the crystal the external clock source.
// - Crystal enable takes clock input from crystal and forces both pin enables off.
// - Bit 2 set bypasses the input glitch filter; clear routes through it.
// - Clock-out select picks 24 MHz, external, 32 kHz or divided CPU clock.
// - Interval prescaler divides its source by 1, 2, 3 or 4.
// - Interval source picks 24 MHz, external, 32 kHz or capture timer clock.
// - Interval timer counts down 12 bits and reloads on the clock after zero.
// - Every reload raises an interrupt request.
// - Reload value stays readable and writable while counting; firmware avoids half writes.
// - Capture divider divides by 2, 4, 6 or 8 and resets to code 10.
// - Capture source picks 24 MHz, external, 32 kHz, or stops the clock.
// - The 1024 us tick is counted from the capture timer clock.
// - Source switches need both clocks running; no switch away from stopped capture clock.
// - Fine offset bits 7..5 add 7.5, 15 and 30 kHz; reset to zero.
// - Gain field bits scale the offset step; lower values give larger steps.
// - Trimmed fields have undefined reset contents and are loaded by boot firmware; here reset clears them to zero.
// - Low-power bit puts the 32 kHz oscillator into its reduced accuracy mode.
// - CPU source select bit chooses internal 24 MHz when 0, external when 1.
package cst_pkg;
    localparam logic [7:0] CST_OFF_CPU_SRC = 8'h30;
    localparam logic [7:0] CST_OFF_TMR_CFG = 8'h31;
    localparam logic [7:0] CST_OFF_PIN_CFG = 8'h32;
    localparam logic [7:0] CST_OFF_MAIN_TRIM = 8'h34;
    localparam logic [7:0] CST_OFF_XTAL_TRIM = 8'h35;
    localparam logic [7:0] CST_OFF_SLOW_TRIM = 8'h36;
    localparam logic [7:0] CST_OFF_RELOAD_LO = 8'h40;
    localparam logic [7:0] CST_OFF_RELOAD_HI = 8'h44;
    localparam logic [7:0] CST_OFF_CPU_SPEED = 8'hE0;
    localparam logic [7:0] CST_OFF_FLAGS = 8'hF0;
    localparam logic [7:0] CST_OFF_STATUS = 8'hF4;
    localparam logic [7:0] CST_RST_TMR_CFG = 8'h8F;
    localparam logic [7:0] CST_RST_PIN_CFG = 8'h00;
    localparam logic [7:0] CST_RST_TRIM = 8'h00;
    localparam logic [2:0] CST_RST_SPEED = 3'h0;
    localparam logic [7:0] CST_MASK_PIN_CFG = 8'h1F;
    localparam logic [7:0] CST_MASK_XTAL_TRIM = 8'h1D;
    localparam logic [7:0] CST_MASK_SLOW_TRIM = 8'hBF;
    localparam int CST_BIT_XSEL = 4;
    localparam int CST_BIT_XEN = 3;
    localparam int CST_BIT_FBYP = 2;
    localparam int CST_BIT_LOWPWR = 7;
    localparam int CST_TICK_DIV = 4096;
    localparam int CST_CLK_NS = 20;
    typedef struct packed {
        logic [1:0] cap_div;
        logic [1:0] cap_src;
        logic [1:0] itm_div;
        logic [1:0] itm_src;
    } cst_tmr_cfg_t;
    typedef struct packed {
        logic osc_main;
        logic osc_slow;
        logic xtal;
        logic pin0;
    } cst_src_t;
    typedef enum logic [2:0] {
        CST_IDLE = 3'b001,
        CST_RESP = 3'b010,
        CST_RDAT = 3'b100
    } cst_bus_t;
endpackage

// ==== test/cst_src_model.sv ====
// Behavioural model of the oscillators and the clock input pin.
`timescale 1ns/1ns
module cst_src_model (
    // Clock.
    input wire logic aclk,
    // Control from the block.
    input wire logic crystal_osc_en,
    // Source levels.
    output cst_pkg::cst_src_t src
);
    import cst_pkg::*;
    logic [7:0] n = 8'h00;
    logic [5:0] warm = 6'h00;
    initial src = '0;
    always @(posedge aclk) begin
        n <= n + 8'h01;
        // Crystal start-up, scaled down to 63 cycles after enable.
        warm <= crystal_osc_en ? warm + {5'h00, warm != 6'h3F} : 6'h00;
        if (n[0]) begin
            src.osc_main <= ~src.osc_main;
        end
        if (n[3:0] == 4'hF) begin
            src.osc_slow <= ~src.osc_slow;
        end
        // A disabled crystal stands still, so a premature select sees no edges.
        if (crystal_osc_en && warm == 6'h3F && n[1:0] == 2'h3) begin
            src.xtal <= ~src.xtal;
        end
        if (n[2:0] == 3'h7) begin
            src.pin0 <= ~src.pin0;
        end
    end
endmodule

// ==== test/cst_clock_select_tb_top.sv ====
// Register-level testbench of the clock select and interval timer block.
`timescale 1ns/1ns
module cst_clock_select_tb_top;
    import cst_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic bvalid, rvalid, cpu_en, xen, irq, tick, fen, oe0, oe1, lpw;
    logic awready, wready, arready;
    cst_src_t src;
    int error_cnt = 0, total_checks = 0, n_irq = 0, n_tick = 0, n_cpu = 0;
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        n_irq <= n_irq + int'(irq === 1'b1);
        n_tick <= n_tick + int'(tick === 1'b1);
        n_cpu <= n_cpu + int'(cpu_en === 1'b1);
    end
    cst_src_model u_src (.aclk(aclk), .crystal_osc_en(xen), .src(src));
    cst_clock_select #(.TIMER_BITS(12), .TICK_DIV(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_in(src), .cpu_core_clock_en(cpu_en),
        .clock_out_pin(), .ext_clock_in_pin(), .port0_pin0_oe_n_force(oe0),
        .port0_pin1_oe_n_force(oe1), .input_glitch_filter_en(fen), .crystal_osc_en(xen),
        .low_power_osc_lowpwr(lpw), .internal_main_osc_trim(), .crystal_osc_trim(),
        .low_power_osc_trim(), .interval_irq(irq), .tick_1024us(tick));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        chk(32'(got > exp - 2 && got < exp + 2), 32'h1);
    endtask
    // Offsets are word indices; each valid is held until its own ready is seen.
    // The trailing edge keeps a release and the next request out of one time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= {a, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        araddr <= {a, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    // Counts pulses over 320 cycles after the synchronisers settle.
    task automatic meas(input int ei, input int et, input int ec);
        int i0, t0, c0;
        repeat (20) @(posedge aclk);
        i0 = n_irq;
        t0 = n_tick;
        c0 = n_cpu;
        repeat (320) @(posedge aclk);
        near(n_irq - i0, ei);
        near(n_tick - t0, et);
        near(n_cpu - c0, ec);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h31, 8'h8F, 2'h0);
        rd(8'h32, 8'h00, 2'h0);
        rd(8'h34, 8'h00, 2'h0);
        chk({31'h0, fen}, 32'h1);
        rd(8'hE0, 8'h00, 2'h2);
        wr(8'hF0, 8'h01, 2'h0);
        rd(8'hE0, 8'h00, 2'h0);
        $display("test reset done");
        wr(8'h31, 8'h00, 2'h0);
        wr(8'h40, 8'h03, 2'h0);
        wr(8'h44, 8'h00, 2'h0);
        rd(8'h40, 8'h03, 2'h0);
        meas(20, 10, 10);
        wr(8'hE0, 8'h02, 2'h0);
        rd(8'hE0, 8'h02, 2'h0);
        wr(8'h31, 8'h34, 2'h0);
        meas(10, 0, 40);
        $display("test timers done");
        wr(8'hE0, 8'h00, 2'h0);
        wr(8'h32, 8'h08, 2'h0);
        chk({30'h0, oe0, oe1}, 32'h3);
        repeat (70) @(posedge aclk);
        wr(8'h32, 8'h18, 2'h0);
        wr(8'h30, 8'h01, 2'h0);
        meas(10, 0, 5);
        wr(8'h30, 8'h00, 2'h0);
        wr(8'h32, 8'h08, 2'h0);
        wr(8'h32, 8'h04, 2'h0);
        chk({30'h0, oe0, fen}, 32'h0);
        wr(8'h36, 8'h80, 2'h0);
        chk({31'h0, lpw}, 32'h1);
        rd(8'h36, 8'h80, 2'h0);
        rd(8'h38, 8'h00, 2'h2);
        wr(8'h31, 8'h37, 2'h0);
        wr(8'h31, 8'h00, 2'h0);
        rd(8'h31, 8'h03, 2'h0);
        $display("test pins done");
        give_verdict();
    end
endmodule
